// *** logic/omcd_pkg.sv ***
// Purpose: Shared constants and types of the optical module control block
// Assumes: 125 MHz pclk on both ends
// Notes:   Management window stands for the module's serial register access
package omcd_pkg;
  // Timing
  localparam int unsigned CLK_HZ           = 125_000_000;
  localparam int unsigned BER_INTERVAL_S   = 5;
  localparam int unsigned BER_INTERVAL_CYC = BER_INTERVAL_S * CLK_HZ;
  // Line rates
  typedef enum logic [1:0] {OMCD_R16G, OMCD_R32G, OMCD_R64G} omcd_rate_t;
  // Module management map (8-bit address, 8-bit data)
  localparam logic [7:0] MA_CTRL    = 8'h00;
  localparam logic [7:0] MA_EMPH    = 8'h01;
  localparam logic [7:0] MA_PRBS    = 8'h02;
  localparam logic [7:0] MA_BER_LO  = 8'h03;
  localparam logic [7:0] MA_BER_HI  = 8'h04;
  localparam logic [7:0] MA_STATUS  = 8'h05;
  localparam logic [7:0] MA_MON_TXP = 8'h10;
  localparam logic [7:0] MA_MON_RXP = 8'h11;
  localparam logic [7:0] MA_MON_TMP = 8'h12;
  localparam logic [7:0] MA_MON_VCC = 8'h13;
  localparam logic [7:0] MA_MON_BIA = 8'h14;
  // Module field positions
  localparam int CB_RATE64 = 0;
  localparam int CB_OLOOP  = 1;
  localparam int CB_ELOOP  = 2;
  localparam int CB_PASS   = 3;
  localparam int PB_GEN    = 0;
  localparam int PB_LINE   = 1;
  localparam int PB_P15    = 2;
  localparam int PB_CHK    = 3;
  localparam int SB_DONE   = 4;
  localparam logic [7:0] CTRL_RST = 8'h08;
  localparam logic [7:0] EMPH_RST = 8'h00;
  localparam logic [7:0] PRBS_RST = 8'h00;
  localparam logic [3:0] EQ_RST   = 4'h8;
  localparam logic [14:0] LFSR_SEED = 15'h7fff;
  // Controller APB map
  localparam logic [7:0] HA_PINS  = 8'h00;
  localparam logic [7:0] HA_CMD   = 8'h04;
  localparam logic [7:0] HA_MSTAT = 8'h08;
  localparam logic [7:0] HA_ISTAT = 8'h0c;
  localparam logic [7:0] HA_IMASK = 8'h10;
  localparam logic [7:0] HA_PSTAT = 8'h14;
  localparam int HB_TXRATE = 0;
  localparam int HB_RXRATE = 1;
  localparam int HB_TXDIS  = 2;
  localparam logic [2:0] PINS_RST = 3'h4;
  localparam int HB_CMD_WR = 16;
  localparam int IB_DONE   = 0;
  localparam int IB_FAULT  = 1;
  localparam int IB_LOST   = 2;
  typedef enum logic [1:0] {OMCD_IDLE, OMCD_WAIT, OMCD_DROP} omcd_mst_t;
endpackage : omcd_pkg

// *** logic/omcd_link_if.sv ***
// Purpose: Pins between module and controller
// Assumes: Both ends clocked by the same pclk
// Notes:   mgmt_* is a held-request, one-cycle-ack register channel
`timescale 1ns/100ps
`default_nettype none
interface omcd_link_if;
  logic       tx_rate_sel;
  logic       rx_rate_sel;
  logic       tx_disable;
  logic       tx_fault;
  logic       rx_light_lost;
  logic       mgmt_req;
  logic       mgmt_wr;
  logic [7:0] mgmt_addr;
  logic [7:0] mgmt_wdata;
  logic       mgmt_ack;
  logic [7:0] mgmt_rdata;
  modport dev (input tx_rate_sel, rx_rate_sel, tx_disable, mgmt_req, mgmt_wr, mgmt_addr,
               mgmt_wdata, output tx_fault, rx_light_lost, mgmt_ack, mgmt_rdata);
  modport hst (output tx_rate_sel, rx_rate_sel, tx_disable, mgmt_req, mgmt_wr, mgmt_addr,
               mgmt_wdata, input tx_fault, rx_light_lost, mgmt_ack, mgmt_rdata);
endinterface : omcd_link_if
`default_nettype wire

// *** logic/omcd_module.sv ***
// Purpose: Low-speed control and diagnostics inside the optical module
// Assumes: Pins synchronous to pclk; analog paths driven by the select outputs
// Notes:   All state freezes while ce is low
`timescale 1ns/100ps
`default_nettype none
module omcd_module #(
  parameter int unsigned BER_CYC = omcd_pkg::BER_INTERVAL_CYC
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                ce,
  omcd_link_if.dev                 lnk,
  input  wire logic                laser_fault,
  input  wire logic                rx_power_ok,
  input  wire logic                eq_err,
  input  wire logic                eq_dir,
  input  wire logic [7:0]          mon_tx_pwr,
  input  wire logic [7:0]          mon_rx_pwr,
  input  wire logic [7:0]          mon_temp,
  input  wire logic [7:0]          mon_vcc,
  input  wire logic [7:0]          mon_bias,
  input  wire logic                chk_bit,
  input  wire logic                chk_valid,
  output logic                     tx_light_off,
  output omcd_pkg::omcd_rate_t     tx_rate,
  output omcd_pkg::omcd_rate_t     rx_rate,
  output logic                     tx_pam4,
  output logic                     rx_pam4,
  output logic                     opt_loop,
  output logic                     elec_loop,
  output logic                     pass_thru,
  output logic [3:0]               eq_setting,
  output logic [3:0]               emphasis,
  output logic                     prbs_sys_bit,
  output logic                     prbs_sys_en,
  output logic                     prbs_line_bit,
  output logic                     prbs_line_en,
  output logic                     ber_done
);
  import omcd_pkg::*;

  logic [7:0]  ctrl_q;
  logic [7:0]  emph_q;
  logic [7:0]  prbs_q;
  logic [14:0] gen_q;
  logic [14:0] chk_q;
  logic [15:0] err_cnt_q;
  logic [15:0] err_held_q;
  logic [29:0] tick_q;
  logic        done_flag_q;
  logic        wr_hit;
  logic        rd_hit;
  logic        interval_end;
  logic        chk_miss;

  // Pin level plus top-rate register picks the lane rate
  function automatic omcd_rate_t rate_of(input logic pin, input logic top);
    if (top) rate_of = OMCD_R64G;
    else if (pin) rate_of = OMCD_R32G;
    else rate_of = OMCD_R16G;
  endfunction : rate_of

  // Feedback tap of the selected polynomial, x^7+x^6+1 or x^15+x^14+1
  function automatic logic tap_of(input logic [14:0] s, input logic p15);
    tap_of = p15 ? (s[14] ^ s[13]) : (s[6] ^ s[5]);
  endfunction : tap_of

  assign wr_hit       = lnk.mgmt_req & ~lnk.mgmt_ack & lnk.mgmt_wr;
  assign rd_hit       = lnk.mgmt_req & ~lnk.mgmt_ack & ~lnk.mgmt_wr;
  assign interval_end = (tick_q == 30'(BER_CYC - 1));
  assign chk_miss     = chk_valid & (chk_bit != tap_of(chk_q, prbs_q[PB_P15]));

  // Management handshake: one ack per held request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lnk.mgmt_ack <= 1'b0;
    end else if (ce) begin
      lnk.mgmt_ack <= lnk.mgmt_req & ~lnk.mgmt_ack;
    end
  end

  // Writable settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      emph_q <= EMPH_RST;
      prbs_q <= PRBS_RST;
    end else if (ce && wr_hit) begin
      if (lnk.mgmt_addr == MA_CTRL) ctrl_q <= lnk.mgmt_wdata;
      if (lnk.mgmt_addr == MA_EMPH) emph_q <= lnk.mgmt_wdata;
      if (lnk.mgmt_addr == MA_PRBS) prbs_q <= lnk.mgmt_wdata;
    end
  end

  // Read data; unmapped addresses read zero, reading status clears the done flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lnk.mgmt_rdata <= 8'h00;
    end else if (ce && rd_hit) begin
      case (lnk.mgmt_addr)
        MA_CTRL:    lnk.mgmt_rdata <= ctrl_q;
        MA_EMPH:    lnk.mgmt_rdata <= emph_q;
        MA_PRBS:    lnk.mgmt_rdata <= prbs_q;
        MA_BER_LO:  lnk.mgmt_rdata <= err_held_q[7:0];
        MA_BER_HI:  lnk.mgmt_rdata <= err_held_q[15:8];
        MA_STATUS:  lnk.mgmt_rdata <= {3'h0, done_flag_q, eq_setting};
        MA_MON_TXP: lnk.mgmt_rdata <= mon_tx_pwr;
        MA_MON_RXP: lnk.mgmt_rdata <= mon_rx_pwr;
        MA_MON_TMP: lnk.mgmt_rdata <= mon_temp;
        MA_MON_VCC: lnk.mgmt_rdata <= mon_vcc;
        MA_MON_BIA: lnk.mgmt_rdata <= mon_bias;
        default:    lnk.mgmt_rdata <= 8'h00;
      endcase
    end
  end

  // Status pins and laser shutdown; reset keeps the laser dark
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lnk.tx_fault      <= 1'b0;
      lnk.rx_light_lost <= 1'b1;
      tx_light_off      <= 1'b1;
    end else if (ce) begin
      lnk.tx_fault      <= laser_fault;
      lnk.rx_light_lost <= ~rx_power_ok;
      tx_light_off      <= lnk.tx_disable;
    end
  end

  // Lane rate and modulation for the recovery stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_rate <= OMCD_R16G;
      rx_rate <= OMCD_R16G;
      tx_pam4 <= 1'b0;
      rx_pam4 <= 1'b0;
    end else if (ce) begin
      tx_rate <= rate_of(lnk.tx_rate_sel, ctrl_q[CB_RATE64]);
      rx_rate <= rate_of(lnk.rx_rate_sel, ctrl_q[CB_RATE64]);
      tx_pam4 <= ctrl_q[CB_RATE64];
      rx_pam4 <= ctrl_q[CB_RATE64];
    end
  end

  // Loopback steering and emphasis
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_loop  <= 1'b0;
      elec_loop <= 1'b0;
      pass_thru <= 1'b1;
      emphasis  <= 4'h0;
    end else if (ce) begin
      opt_loop  <= ctrl_q[CB_OLOOP];
      elec_loop <= ctrl_q[CB_ELOOP];
      // Outside loopback traffic always passes; the bit only matters in a wrap
      pass_thru <= ~(ctrl_q[CB_OLOOP] | ctrl_q[CB_ELOOP]) | ctrl_q[CB_PASS];
      emphasis  <= emph_q[3:0];
    end
  end

  // Adaptive input EQ: step on each error hint, saturating at both ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eq_setting <= EQ_RST;
    end else if (ce && eq_err) begin
      if (eq_dir && eq_setting != 4'hf) eq_setting <= eq_setting + 4'h1;
      else if (!eq_dir && eq_setting != 4'h0) eq_setting <= eq_setting - 4'h1;
    end
  end

  // Pattern generator; steps one bit per enabled pclk cycle, whatever the lane rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_q         <= LFSR_SEED;
      prbs_sys_bit  <= 1'b0;
      prbs_line_bit <= 1'b0;
      prbs_sys_en   <= 1'b0;
      prbs_line_en  <= 1'b0;
    end else if (ce) begin
      if (prbs_q[PB_GEN]) gen_q <= {gen_q[13:0], tap_of(gen_q, prbs_q[PB_P15])};
      prbs_sys_en   <= prbs_q[PB_GEN] & ~prbs_q[PB_LINE];
      prbs_line_en  <= prbs_q[PB_GEN] & prbs_q[PB_LINE];
      prbs_sys_bit  <= prbs_q[PB_GEN] & ~prbs_q[PB_LINE] & tap_of(gen_q, prbs_q[PB_P15]);
      prbs_line_bit <= prbs_q[PB_GEN] & prbs_q[PB_LINE] & tap_of(gen_q, prbs_q[PB_P15]);
    end
  end

  // Interval timer; fixed length, software cannot change it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 30'h0;
    end else if (ce) begin
      if (!prbs_q[PB_CHK] || interval_end) tick_q <= 30'h0;
      else tick_q <= tick_q + 30'h1;
    end
  end

  // Self-synchronising checker: history of received bits predicts the next
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_q     <= 15'h0;
      err_cnt_q <= 16'h0;
    end else if (ce) begin
      if (chk_valid) chk_q <= {chk_q[13:0], chk_bit};
      if (!prbs_q[PB_CHK] || interval_end) err_cnt_q <= 16'h0;
      else if (chk_miss && err_cnt_q != 16'hffff) err_cnt_q <= err_cnt_q + 16'h1;
    end
  end

  // Result hold; a new interval end wins over the clear-on-read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_held_q  <= 16'h0;
      done_flag_q <= 1'b0;
      ber_done    <= 1'b0;
    end else if (ce) begin
      ber_done <= prbs_q[PB_CHK] & interval_end;
      if (prbs_q[PB_CHK] && interval_end) begin
        err_held_q  <= chk_miss && err_cnt_q != 16'hffff ? err_cnt_q + 16'h1 : err_cnt_q;
        done_flag_q <= 1'b1;
      end else if (rd_hit && lnk.mgmt_addr == MA_STATUS) begin
        done_flag_q <= 1'b0;
      end
    end
  end
endmodule : omcd_module
`default_nettype wire

// *** logic/omcd_ctrl.sv ***
// Purpose: Controller end: drives module pins, runs management requests from APB
// Assumes: APB slave, 32-bit data, no wait state on any access
// Notes:   Interrupt events: request done, fault rise, loss rise
`timescale 1ns/100ps
`default_nettype none
module omcd_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  omcd_link_if.hst         lnk,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             irq
);
  import omcd_pkg::*;

  omcd_mst_t  st_q;
  logic [7:0] rdata_q;
  logic [2:0] istat_q;
  logic [2:0] imask_q;
  logic       fault_q;
  logic       lost_q;
  logic       acc;
  logic       wr_en;
  logic [2:0] ev;

  assign acc   = psel & penable & pready;
  assign wr_en = acc & pwrite;
  assign ev    = {lnk.rx_light_lost & ~lost_q, lnk.tx_fault & ~fault_q, lnk.mgmt_ack};

  // No wait state: ready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= psel & ~pready;
      pslverr <= psel & ~pready & (paddr[7:0] > HA_PSTAT || paddr[1:0] != 2'h0 ||
                                   paddr[31:8] != 24'h0);
      if (psel && !pready && !pwrite) begin
        case (paddr[7:0])
          HA_PINS:  prdata <= {29'h0, lnk.tx_disable, lnk.rx_rate_sel, lnk.tx_rate_sel};
          HA_MSTAT: prdata <= {16'h0, rdata_q, 7'h0, st_q != OMCD_IDLE};
          HA_ISTAT: prdata <= {29'h0, istat_q};
          HA_IMASK: prdata <= {29'h0, imask_q};
          HA_PSTAT: prdata <= {30'h0, lnk.rx_light_lost, lnk.tx_fault};
          default:  prdata <= 32'h0;
        endcase
      end
    end
  end

  // Module pins driven from software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {lnk.tx_disable, lnk.rx_rate_sel, lnk.tx_rate_sel} <= PINS_RST;
    end else if (ce && wr_en && paddr[7:0] == HA_PINS) begin
      lnk.tx_rate_sel <= pwdata[HB_TXRATE];
      lnk.rx_rate_sel <= pwdata[HB_RXRATE];
      lnk.tx_disable  <= pwdata[HB_TXDIS];
    end
  end

  // Management request: held until ack, a write while busy is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q           <= OMCD_IDLE;
      lnk.mgmt_req   <= 1'b0;
      lnk.mgmt_wr    <= 1'b0;
      lnk.mgmt_addr  <= 8'h00;
      lnk.mgmt_wdata <= 8'h00;
      rdata_q        <= 8'h00;
    end else if (ce) begin
      case (st_q)
        OMCD_IDLE: begin
          if (wr_en && paddr[7:0] == HA_CMD) begin
            lnk.mgmt_req   <= 1'b1;
            lnk.mgmt_wr    <= pwdata[HB_CMD_WR];
            lnk.mgmt_addr  <= pwdata[15:8];
            lnk.mgmt_wdata <= pwdata[7:0];
            st_q           <= OMCD_WAIT;
          end
        end
        OMCD_WAIT: begin
          if (lnk.mgmt_ack) begin
            lnk.mgmt_req <= 1'b0;
            rdata_q      <= lnk.mgmt_rdata;
            st_q         <= OMCD_DROP;
          end
        end
        OMCD_DROP: st_q <= OMCD_IDLE;
        default:   st_q <= OMCD_IDLE;
      endcase
    end
  end

  // Sticky events, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_q <= 3'h0;
      imask_q <= 3'h0;
      fault_q <= 1'b0;
      lost_q  <= 1'b1;
      irq     <= 1'b0;
    end else if (ce) begin
      fault_q <= lnk.tx_fault;
      lost_q  <= lnk.rx_light_lost;
      if (wr_en && paddr[7:0] == HA_IMASK) imask_q <= pwdata[2:0];
      if (wr_en && paddr[7:0] == HA_ISTAT) istat_q <= (istat_q & ~pwdata[2:0]) | ev;
      else istat_q <= istat_q | ev;
      irq <= |(istat_q & imask_q);
    end
  end
endmodule : omcd_ctrl
`default_nettype wire

// *** verification/omcd_checker.sv ***
// Purpose: Assertions on the link between controller and module
// Assumes: Single pclk domain, presetn async active low
// Notes:   Takes link signals as plain inputs, instantiated by the bench
`timescale 1ns/100ps
`default_nettype none
module omcd_checker (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       tx_disable,
  input wire logic       tx_fault,
  input wire logic       rx_light_lost,
  input wire logic       mgmt_req,
  input wire logic       mgmt_wr,
  input wire logic [7:0] mgmt_addr,
  input wire logic [7:0] mgmt_wdata,
  input wire logic       mgmt_ack,
  input wire logic [7:0] mgmt_rdata
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Leaving reset the laser stays dark and light counts as lost
  chk_rst_safe: assert property (
    $rose(presetn) |-> tx_disable && rx_light_lost && !mgmt_req)
    else $error("unsafe pins after reset");
  // A request is answered in the cycle after the module sees it
  chk_ack_prompt: assert property (
    $rose(mgmt_req) |=> mgmt_ack) else $error("no ack after request");
  chk_ack_single: assert property (
    mgmt_ack |=> !mgmt_ack) else $error("ack longer than one cycle");
  chk_ack_cause: assert property (
    mgmt_ack |-> mgmt_req) else $error("ack without request");
  // The request stays whole until answered, else the module may latch a torn write
  chk_req_held: assert property (
    mgmt_req && !mgmt_ack |=> mgmt_req && $stable({mgmt_wr, mgmt_addr, mgmt_wdata}))
    else $error("request changed before ack");
  chk_req_release: assert property (
    mgmt_ack |=> !mgmt_req) else $error("request kept after ack");
  chk_drop_gap: assert property (
    $fell(mgmt_req) |=> !mgmt_req) else $error("no idle cycle between requests");
  // Read data only moves with the answer to a read
  chk_rdata_hold: assert property (
    $changed(mgmt_rdata) |-> mgmt_ack && !mgmt_wr) else $error("read data moved without read");
  cover property (mgmt_ack && mgmt_wr);
  cover property (mgmt_ack && !mgmt_wr);
  cover property ($rose(tx_fault));
  cover property ($rose(rx_light_lost));
endmodule : omcd_checker
`default_nettype wire

// *** verification/omcd_test.sv ***
// Purpose: Self-checking bench joining controller and module ends
// Assumes: APB master in the bench, error interval shortened to 64 cycles
// Notes:   APB read results are checked by a monitor against queued notes
`timescale 1ns/100ps
`default_nettype none
module omcd_test;
  import omcd_pkg::*;
  localparam int unsigned BC = 64;
  logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rnd;
  logic        pready, pslverr, irq, inj = 1'b0, gb, gp15 = 1'b0;
  logic [14:0] gh = '0;
  logic        laser_fault = 1'b0, rx_power_ok = 1'b1, eq_err = 1'b0, eq_dir = 1'b0;
  logic        chk_bit = 1'b0, chk_valid = 1'b0;
  logic [7:0]  mon_v [5];
  logic [6:0]  lfsr = 7'h7f;
  logic        tx_light_off, tx_pam4, rx_pam4, opt_loop, elec_loop, pass_thru;
  logic        prbs_sys_bit, prbs_sys_en, prbs_line_bit, prbs_line_en, ber_done;
  logic [3:0]  eq_setting, emphasis, v;
  omcd_rate_t  tx_rate, rx_rate;
  logic [32:0] expq [$];
  int          num_errors = 0, checked = 0, cyc = 0, t0, gn = 0;

  always #4 pclk = ~pclk;
  omcd_link_if omcd_link_if_i ();
  omcd_module #(.BER_CYC(BC)) omcd_module_i (.pclk, .presetn, .ce, .lnk(omcd_link_if_i),
    .laser_fault, .rx_power_ok, .eq_err, .eq_dir, .mon_tx_pwr(mon_v[0]), .mon_rx_pwr(mon_v[1]),
    .mon_temp(mon_v[2]), .mon_vcc(mon_v[3]), .mon_bias(mon_v[4]), .chk_bit, .chk_valid,
    .tx_light_off, .tx_rate, .rx_rate, .tx_pam4, .rx_pam4, .opt_loop, .elec_loop, .pass_thru,
    .eq_setting, .emphasis, .prbs_sys_bit, .prbs_sys_en, .prbs_line_bit, .prbs_line_en,
    .ber_done);
  omcd_ctrl omcd_ctrl_i (.pclk, .presetn, .ce, .lnk(omcd_link_if_i), .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .irq);
  omcd_checker omcd_checker_i (.pclk, .presetn, .tx_disable(omcd_link_if_i.tx_disable),
    .tx_fault(omcd_link_if_i.tx_fault), .rx_light_lost(omcd_link_if_i.rx_light_lost),
    .mgmt_req(omcd_link_if_i.mgmt_req), .mgmt_wr(omcd_link_if_i.mgmt_wr),
    .mgmt_addr(omcd_link_if_i.mgmt_addr), .mgmt_wdata(omcd_link_if_i.mgmt_wdata),
    .mgmt_ack(omcd_link_if_i.mgmt_ack), .mgmt_rdata(omcd_link_if_i.mgmt_rdata));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic cmp(input logic [32:0] e, input logic [32:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp

  task automatic c1(input logic e, input logic g);
    cmp({32'h0, e}, {32'h0, g});
  endtask : c1

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : wt

  // One APB transfer; the request holds until pready is seen at an edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [31:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // Management access; the fixed wait covers ack, drop cycle and busy clear
  task automatic mg(input logic w, input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, {24'h0, HA_CMD}, {15'h0, w, a, d});
    repeat (6) @(posedge pclk);
    apb(1'b1, {24'h0, HA_ISTAT}, 32'h1);
  endtask : mg

  task automatic mrd(input logic [7:0] a, input logic [7:0] e);
    mg(1'b0, a, 8'h0);
    rd({24'h0, HA_MSTAT}, {17'h0, e, 8'h0});
  endtask : mrd

  task automatic eqp(input logic d, input int n);
    repeat (n) begin
      @(posedge pclk);
      eq_err <= 1'b1;
      eq_dir <= d;
      @(posedge pclk);
      eq_err <= 1'b0;
    end
    wt(2);
  endtask : eqp

  task automatic wait_done();
    int n;
    n = 0;
    do @(posedge pclk); while (ber_done !== 1'b1 && ++n < 200);
  endtask : wait_done

  // Read results are compared at the completing edge, oldest note first
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      cmp(expq.pop_front(), {pslverr, prdata});
    end
  end

  // PRBS7 reference stream into the checker; inj flips one bit only
  always @(posedge pclk) begin
    lfsr <= {lfsr[5:0], lfsr[6] ^ lfsr[5]};
    chk_bit <= lfsr[6] ^ lfsr[5] ^ inj;
  end

  // Generator output must obey its polynomial once a full history is seen
  always @(posedge pclk) begin
    if (prbs_sys_en || prbs_line_en) begin
      gb = prbs_sys_en ? prbs_sys_bit : prbs_line_bit;
      if (gn >= (gp15 ? 15 : 7)) c1(gp15 ? gh[14] ^ gh[13] : gh[6] ^ gh[5], gb);
      gh <= {gh[13:0], gb};
      gn <= gn + 1;
    end else begin
      gn <= 0;
    end
  end

  // Hang guard, well above the length of the full sequence
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc > 30000) begin
      num_errors++;
      stop_test();
    end
  end

  initial begin
    rnd = $urandom(32);
    foreach (mon_v[i]) mon_v[i] = 8'($urandom);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk_valid <= 1'b1;
    wt(2);
    c1(1'b1, tx_light_off);
    c1(1'b1, pass_thru);
    cmp({29'h0, EQ_RST}, {29'h0, eq_setting});
    rd({24'h0, HA_PINS}, {30'h0, PINS_RST});
    rd({24'h0, HA_PSTAT}, 33'h0);
    mrd(MA_CTRL, CTRL_RST);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      rnd = $urandom;
      apb(1'b1, {24'h0, HA_PINS}, {29'h0, rnd[2:0]});
      wt(2);
      c1(rnd[2], tx_light_off);
      cmp({31'h0, rnd[0] ? OMCD_R32G : OMCD_R16G}, {31'h0, tx_rate});
      cmp({31'h0, rnd[1] ? OMCD_R32G : OMCD_R16G}, {31'h0, rx_rate});
      rd({24'h0, HA_PINS}, {30'h0, rnd[2:0]});
    end
    apb(1'b1, {24'h0, HA_PINS}, 32'h3);
    for (int i = 0; i < 16; i++) begin
      v = 4'(i);
      mg(1'b1, MA_CTRL, {4'h0, v});
      c1(v[1], opt_loop);
      c1(v[2], elec_loop);
      c1(!(v[1] | v[2]) | v[3], pass_thru);
      c1(v[0], rx_pam4);
      c1(v[0], tx_pam4);
      cmp({31'h0, v[0] ? OMCD_R64G : OMCD_R32G}, {31'h0, tx_rate});
      cmp({31'h0, v[0] ? OMCD_R64G : OMCD_R32G}, {31'h0, rx_rate});
    end
    mg(1'b1, MA_CTRL, CTRL_RST);
    rnd = $urandom;
    mg(1'b1, MA_EMPH, {4'h0, rnd[3:0]});
    cmp({29'h0, rnd[3:0]}, {29'h0, emphasis});
    mrd(MA_EMPH, {4'h0, rnd[3:0]});
    for (int i = 0; i < 5; i++) mrd(8'(MA_MON_TXP + i), mon_v[i]);
    rd(32'h18, 33'h100000000);
    mrd(8'h20, 8'h00);
    $display("control test done");
    eqp(1'b1, 3);
    mrd(MA_STATUS, 8'h0b);
    eqp(1'b1, 6);
    cmp(33'hf, {29'h0, eq_setting});
    eqp(1'b0, 17);
    cmp(33'h0, {29'h0, eq_setting});
    // With the enable low the hints must leave the setting frozen
    @(posedge pclk);
    ce <= 1'b0;
    eqp(1'b1, 2);
    cmp(33'h0, {29'h0, eq_setting});
    @(posedge pclk);
    ce <= 1'b1;
    apb(1'b1, {24'h0, HA_IMASK}, 32'h6);
    @(posedge pclk);
    laser_fault <= 1'b1;
    wt(4);
    c1(1'b1, irq);
    rd({24'h0, HA_PSTAT}, 33'h1);
    rd({24'h0, HA_ISTAT}, 33'h2);
    apb(1'b1, {24'h0, HA_ISTAT}, 32'h2);
    wt(2);
    c1(1'b0, irq);
    apb(1'b1, {24'h0, HA_IMASK}, 32'h2);
    @(posedge pclk);
    rx_power_ok <= 1'b0;
    wt(4);
    c1(1'b0, irq);
    rd({24'h0, HA_PSTAT}, 33'h3);
    rd({24'h0, HA_ISTAT}, 33'h4);
    apb(1'b1, {24'h0, HA_IMASK}, 32'h6);
    wt(2);
    c1(1'b1, irq);
    apb(1'b1, {24'h0, HA_ISTAT}, 32'h4);
    wt(2);
    c1(1'b0, irq);
    $display("equaliser and interrupt test done");
    mg(1'b1, MA_PRBS, 8'h01);
    c1(1'b1, prbs_sys_en);
    c1(1'b0, prbs_line_en);
    mg(1'b1, MA_PRBS, 8'h03);
    c1(1'b0, prbs_sys_en);
    c1(1'b1, prbs_line_en);
    mg(1'b1, MA_PRBS, 8'h08);
    wait_done();
    t0 = cyc;
    wait_done();
    cmp(33'(BC), 33'(cyc - t0));
    mrd(MA_STATUS, 8'h10);
    mrd(MA_BER_LO, 8'h00);
    @(posedge pclk);
    inj <= 1'b1;
    @(posedge pclk);
    inj <= 1'b0;
    wait_done();
    mrd(MA_BER_LO, 8'h03);
    mrd(MA_BER_HI, 8'h00);
    gp15 <= 1'b1;
    mg(1'b1, MA_PRBS, 8'h05);
    wt(40);
    c1(1'b1, prbs_sys_en);
    $display("pattern test done");
    stop_test();
  end
endmodule : omcd_test
`default_nettype wire
